// File: rtl/qsfrc_pkg.sv
// How it works
// - controller only: drives clock and select
// - reads over one, two or four lines
// - word length programmable 1 to 128
// - words per frame programmable 1 to 4096
// - three, four or six pin configurations
// - optional word and frame done pulses
// - select-to-data delay of 0 to 3 clocks
// - serial clock mode 0, idles low
// - read data sampled on falling edge
// - select leads first fall by delay+1 periods
// - select drops two periods after last fall
// - primary data line changes on falling edges
// - first command bit set at select, delay+1 periods before first fall
// - any divider value gives even duty
// - processor reads words through word port
package qsfrc_pkg;
    localparam int unsigned MAX_WORD_BITS = 128;
    localparam int unsigned MAX_WORDS = 4096;
    localparam int unsigned CS_TAIL_PERIODS = 2;
    localparam int unsigned DIV_W = 8;
    localparam logic [1:0] WIDTH_SINGLE = 2'h0;
    localparam logic [1:0] WIDTH_DUAL = 2'h1;
    localparam logic [1:0] WIDTH_QUAD = 2'h2;
    localparam logic [1:0] PINS_3 = 2'h0;
    localparam logic [1:0] PINS_4 = 2'h1;
    localparam logic [1:0] PINS_6 = 2'h2;

    typedef struct packed {
        logic [7:0] cmd;
        logic [DIV_W-1:0] serial_clock_divider;
        logic [1:0] cs_lead_delay_field;
        logic [1:0] read_width;
        logic [1:0] pin_mode;
        logic [6:0] word_len_m1;
        logic [11:0] word_cnt_m1;
        logic word_irq_en;
        logic frame_irq_en;
    } qsfrc_cfg_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_LEAD, ST_CMD, ST_DATA, ST_TAIL
    } qsfrc_state_e;
endpackage

// File: rtl/qsfrc_clkdiv.sv
module qsfrc_clkdiv #(
    parameter int unsigned DIV_W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // control
    input wire logic run,
    input wire logic [DIV_W-1:0] div,
    // tick outputs: rise and fall of serial clock
    output logic rise_tick,
    output logic fall_tick
);
    // half period = div+1 system clocks; halves are equal for any div
    logic [DIV_W-1:0] cnt_r;

    if (DIV_W < 2 || DIV_W > 16) begin : g_div_w_check
        $error("qsfrc_clkdiv: DIV_W must be 2 to 16");
    end
    logic phase_r;

    always_ff @(posedge sys_clk) begin
        if (reset || !run) begin
            cnt_r <= '0;
            phase_r <= 1'b0;
        end else if (cnt_r == div) begin
            cnt_r <= '0;
            phase_r <= ~phase_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign rise_tick = run && (cnt_r == div) && !phase_r;
    assign fall_tick = run && (cnt_r == div) && phase_r;
endmodule // qsfrc_clkdiv

// File: rtl/qsfrc_ctrl.sv
module qsfrc_ctrl (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // configuration and start
    input wire qsfrc_pkg::qsfrc_cfg_s cfg,
    input wire logic start,
    // status
    output logic busy,
    // word port to processor side
    output logic [qsfrc_pkg::MAX_WORD_BITS-1:0] rd_word,
    output logic rd_valid,
    output logic word_done_irq,
    output logic frame_done_irq,
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic [3:0] dq_o,
    output logic [3:0] dq_oe,
    input wire logic [3:0] dq_i
);
    qsfrc_pkg::qsfrc_state_e state_r;
    qsfrc_pkg::qsfrc_cfg_s cfg_r;
    logic rise_tick, fall_tick, run;
    logic [3:0] dq_s1_r, dq_s2_r;
    logic [2:0] lead_r;
    logic [3:0] cmd_bit_r;
    logic [6:0] bit_r;
    logic [11:0] word_r;
    logic [1:0] tail_r;
    logic [qsfrc_pkg::MAX_WORD_BITS-1:0] shift_r;
    logic [7:0] cmd_sh_r;

    function automatic logic [2:0] lanes(input logic [1:0] w, input logic [1:0] pins);
        // dual and quad need the extra data pins of the wider modes
        if (w == qsfrc_pkg::WIDTH_QUAD && pins == qsfrc_pkg::PINS_6) lanes = 3'h4;
        else if (w != qsfrc_pkg::WIDTH_SINGLE && pins != qsfrc_pkg::PINS_3) lanes = 3'h2;
        else lanes = 3'h1;
    endfunction

    // lane group enters at the bottom, so the first bit ends up as msb
    function automatic logic [qsfrc_pkg::MAX_WORD_BITS-1:0] shift_in(
        input logic [qsfrc_pkg::MAX_WORD_BITS-1:0] sh, input logic [3:0] d, input logic [2:0] n);
        case (n)
            3'h4: shift_in = {sh[qsfrc_pkg::MAX_WORD_BITS-5:0], d};
            3'h2: shift_in = {sh[qsfrc_pkg::MAX_WORD_BITS-3:0], d[1:0]};
            default: shift_in = {sh[qsfrc_pkg::MAX_WORD_BITS-2:0], d[1]};
        endcase
    endfunction

    // a word closes on the lane group that reaches its length
    function automatic logic word_end(input logic [6:0] bits, input logic [2:0] n,
        input logic [6:0] len_m1);
        word_end = ({1'b0, bits} + {5'h0, n}) > {1'b0, len_m1};
    endfunction

    logic [2:0] lanes_w;
    assign lanes_w = lanes(cfg_r.read_width, cfg_r.pin_mode);

    assign run = (state_r != qsfrc_pkg::ST_IDLE);

    qsfrc_clkdiv #(.DIV_W(qsfrc_pkg::DIV_W)) u_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(run),
        .div(cfg_r.serial_clock_divider),
        .rise_tick(rise_tick),
        .fall_tick(fall_tick)
    );

    // pins are outside the clock domain
    always_ff @(posedge sys_clk) begin
        dq_s1_r <= dq_i;
        dq_s2_r <= dq_s1_r;
    end

    // serial clock runs only between lead and tail; idle low
    always_ff @(posedge sys_clk) begin
        if (reset) sclk <= 1'b0;
        else if (rise_tick && (state_r == qsfrc_pkg::ST_CMD || state_r == qsfrc_pkg::ST_DATA))
            sclk <= 1'b1;
        else if (fall_tick)
            sclk <= 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= qsfrc_pkg::ST_IDLE;
            cfg_r <= '0;
            cs_n <= 1'b1;
            lead_r <= '0;
            cmd_bit_r <= '0;
            bit_r <= '0;
            word_r <= '0;
            tail_r <= '0;
            cmd_sh_r <= '0;
        end else begin
            case (state_r)
                qsfrc_pkg::ST_IDLE: begin
                    if (start) begin
                        cfg_r <= cfg;
                        cs_n <= 1'b0;
                        lead_r <= {1'b0, cfg.cs_lead_delay_field} - 3'h1;
                        cmd_sh_r <= cfg.cmd;
                        cmd_bit_r <= '0;
                        bit_r <= '0;
                        word_r <= '0;
                        // no lead periods: first command period gives the one lead
                        state_r <= (cfg.cs_lead_delay_field == 2'h0) ?
                            qsfrc_pkg::ST_CMD : qsfrc_pkg::ST_LEAD;
                    end
                end
                qsfrc_pkg::ST_LEAD: begin
                    // delay idle periods here, plus the first command period
                    if (fall_tick) begin
                        if (lead_r == 3'h0) state_r <= qsfrc_pkg::ST_CMD;
                        else lead_r <= lead_r - 3'h1;
                    end
                end
                qsfrc_pkg::ST_CMD: begin
                    if (fall_tick && sclk) begin
                        cmd_sh_r <= {cmd_sh_r[6:0], 1'b0};
                        cmd_bit_r <= cmd_bit_r + 4'h1;
                        if (cmd_bit_r == 4'h7) state_r <= qsfrc_pkg::ST_DATA;
                    end
                end
                qsfrc_pkg::ST_DATA: begin
                    if (fall_tick && sclk) begin
                        if (word_end(bit_r, lanes_w, cfg_r.word_len_m1)) begin
                            bit_r <= '0;
                            if (word_r == cfg_r.word_cnt_m1) begin
                                tail_r <= '0;
                                state_r <= qsfrc_pkg::ST_TAIL;
                            end else begin
                                word_r <= word_r + 12'h1;
                            end
                        end else begin
                            bit_r <= bit_r + 7'(lanes(cfg_r.read_width, cfg_r.pin_mode));
                        end
                    end
                end
                qsfrc_pkg::ST_TAIL: begin
                    if (fall_tick) begin
                        if (tail_r == 2'(qsfrc_pkg::CS_TAIL_PERIODS - 1)) begin
                            cs_n <= 1'b1;
                            state_r <= qsfrc_pkg::ST_IDLE;
                        end else tail_r <= tail_r + 2'h1;
                    end
                end
                default: state_r <= qsfrc_pkg::ST_IDLE;
            endcase
        end
    end

    // command out on primary line, moving with the serial clock fall
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dq_o <= '0;
            dq_oe <= '0;
        end else if (state_r == qsfrc_pkg::ST_IDLE && start) begin
            dq_o <= {3'h0, cfg.cmd[7]};
            // dq1 left to the flash from select onward
            dq_oe <= 4'h1;
        end else if (state_r == qsfrc_pkg::ST_CMD && fall_tick && sclk) begin
            dq_o <= {3'h0, cmd_sh_r[6]};
            // all lines released for the read phase
            if (cmd_bit_r == 4'h7) dq_oe <= 4'h0;
        end
    end

    // capture on the falling edge, data launched by flash one fall earlier
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shift_r <= '0;
            rd_word <= '0;
            rd_valid <= 1'b0;
            word_done_irq <= 1'b0;
            frame_done_irq <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            word_done_irq <= 1'b0;
            frame_done_irq <= 1'b0;
            if (state_r == qsfrc_pkg::ST_DATA && fall_tick && sclk) begin
                shift_r <= shift_in(shift_r, dq_s2_r, lanes_w);
                if (word_end(bit_r, lanes_w, cfg_r.word_len_m1)) begin
                    // last lane group must land in the word it closes
                    rd_word <= shift_in(shift_r, dq_s2_r, lanes_w);
                    rd_valid <= 1'b1;
                    word_done_irq <= cfg_r.word_irq_en;
                    frame_done_irq <= cfg_r.frame_irq_en && (word_r == cfg_r.word_cnt_m1);
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) busy <= 1'b0;
        else busy <= run || start;
    end
endmodule // qsfrc_ctrl

// File: dv/qsfrc_ctrl_assertions.sv
module qsfrc_ctrl_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // control and status
    input wire qsfrc_pkg::qsfrc_cfg_s cfg,
    input wire logic start,
    input wire logic busy,
    input wire logic rd_valid,
    input wire logic word_done_irq,
    input wire logic frame_done_irq,
    // serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] dq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_idle_clk_low: assert property (cs_n |-> !sclk)
        else $error("sclk high while deselected");
    a_clk_only_framed: assert property ($changed(sclk) |-> !cs_n)
        else $error("sclk moved outside a frame");
    a_cs_lead_start: assert property (start && !busy && cs_n |=> (!cs_n)[*8])
        else $error("select did not fall and hold after start");
    a_cs_tail_hold: assert property ($fell(sclk) |-> (!cs_n)[*4])
        else $error("select rose too soon after a falling edge");
    a_dq0_on_fall: assert property (!cs_n && !$fell(cs_n) && $changed(dq_o[0]) |-> $fell(sclk))
        else $error("dq0 changed off a falling edge");
    a_valid_one_pulse: assert property (rd_valid |=> !rd_valid)
        else $error("rd_valid longer than one cycle");
    a_word_irq_gate: assert property (word_done_irq |-> cfg.word_irq_en)
        else $error("word pulse while disabled");
    a_frame_irq_gate: assert property (frame_done_irq |-> cfg.frame_irq_en)
        else $error("frame pulse while disabled");
endmodule // qsfrc_ctrl_chk

// File: dv/qsfrc_flash_model.sv
module qsfrc_flash_model (
    // serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dq0,
    // lane value of this frame
    input wire logic [3:0] lane_val,
    output logic [3:0] dq,
    // command byte seen on dq0
    output logic [7:0] cmd_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    int cmd_n = 0;
    initial dq = 4'h0;
    initial cmd_seen = 8'h0;
    // a mode 0 flash takes command bits on rising edges
    always @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cmd_n = 0;
        end else if (cmd_n < 8) begin
            cmd_seen <= {cmd_seen[6:0], dq0};
            cmd_n++;
        end
    end
    // deselected lanes show the inverse, so a stale capture cannot pass
    always @(negedge sclk or posedge cs_n) begin
        dq <= cs_n ? ~lane_val : lane_val;
    end
endmodule // qsfrc_flash_model

// File: dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    qsfrc_pkg::qsfrc_cfg_s cfg = '0;
    logic busy, rd_valid, word_done_irq, frame_done_irq, sclk, cs_n;
    logic [127:0] rd_word;
    logic [3:0] dq_o, dq_oe, dq_i, fl_dq;
    logic [3:0] lane_val = 4'h0;
    logic [7:0] cmd_seen;
    logic [127:0] exp_q[$];
    logic [31:0] seed = 32'h5ddc9643;
    int error_cnt = 0;
    int total_checks = 0;
    always #4 sys_clk = ~sys_clk;
    assign dq_i = (dq_oe & dq_o) | (~dq_oe & fl_dq);
    qsfrc_ctrl u_dut (.sys_clk, .reset, .cfg, .start, .busy, .rd_word, .rd_valid,
        .word_done_irq, .frame_done_irq, .sclk, .cs_n, .dq_o, .dq_oe, .dq_i);
    qsfrc_flash_model u_flash (.sclk, .cs_n, .dq0(dq_i[0]), .lane_val, .dq(fl_dq), .cmd_seen);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic test_done();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [127:0] exp, input logic [127:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            error_cnt++;
            $display("Error %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    initial begin
        int w, len, nw, gw, gwi, gfi, n, pm, ln, p, cs_at, lead, last_fall, tail;
        logic [127:0] exp, mask;
        logic sclk_q, cs_q;
        n = 0;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        for (int i = 0; i < 6 && n < 20000; i++) begin
            seed = xs(seed);
            w = i % 3;
            pm = (i < 3) ? 2 : seed[21:20] % 3;
            // narrower pin modes fall back to fewer lanes
            ln = (w == 2 && pm == 2) ? 4 : (w != 0 && pm != 0) ? 2 : 1;
            p = 2 * (2 * seed[8] + 4);
            len = (i == 5) ? 128 : 4 * (seed[1:0] + 1);
            nw = seed[3:2] % 3 + 1;
            exp = '0;
            mask = '0;
            // lane value is constant per frame, so capture phase is not checked
            for (int b = 0; b < len; b++) begin
                mask[b] = 1'b1;
                exp[b] = (ln == 4) ? seed[4 + b % 4] : (ln == 2) ? seed[4 + b % 2] : seed[5];
            end
            exp_q.delete();
            repeat (nw) exp_q.push_back(exp);
            @(posedge sys_clk);
            lane_val <= seed[7:4];
            cfg <= '{cmd: seed[15:8], serial_clock_divider: 8'(2 * seed[8] + 3),
                cs_lead_delay_field: seed[17:16], read_width: 2'(w), pin_mode: 2'(pm),
                word_len_m1: 7'(len - 1), word_cnt_m1: 12'(nw - 1),
                word_irq_en: seed[18], frame_irq_en: seed[19]};
            start <= 1'b1;
            @(posedge sys_clk);
            start <= 1'b0;
            gw = 0;
            gwi = 0;
            gfi = 0;
            cs_at = -1;
            lead = -1;
            last_fall = -1;
            tail = -1;
            sclk_q = 1'b0;
            cs_q = 1'b1;
            for (n = 0; n < 20000 && (n < 4 || busy !== 1'b0); n++) begin
                @(negedge sys_clk);
                if (rd_valid === 1'b1) begin
                    gw++;
                    if (exp_q.size() == 0) exp_q.push_back(~exp);
                    chk_word(exp_q.pop_front(), rd_word & mask);
                end
                gwi += int'(word_done_irq === 1'b1);
                gfi += int'(frame_done_irq === 1'b1);
                if (cs_n === 1'b0 && cs_at < 0) cs_at = n;
                if (sclk_q === 1'b1 && sclk === 1'b0) begin
                    if (lead < 0) lead = n - cs_at;
                    last_fall = n;
                end
                if (cs_q === 1'b0 && cs_n === 1'b1) tail = n - last_fall;
                sclk_q = sclk;
                cs_q = cs_n;
            end
            if (n == 20000) begin
                error_cnt++;
            end else begin
                chk_cnt(nw, gw);
                chk_cnt(seed[18] ? nw : 0, gwi);
                chk_cnt(int'(seed[19]), gfi);
                chk_cnt((seed[17:16] + 1) * p, lead);
                chk_cnt(qsfrc_pkg::CS_TAIL_PERIODS * p, tail);
                chk_cnt(int'(seed[15:8]), int'(cmd_seen));
            end
        end
        // reset in mid-frame must leave the bus idle at once
        if (n < 20000) begin
            @(posedge sys_clk);
            start <= 1'b1;
            @(posedge sys_clk);
            start <= 1'b0;
            repeat (40) @(posedge sys_clk);
            reset <= 1'b1;
            repeat (2) @(posedge sys_clk);
            reset <= 1'b0;
            @(negedge sys_clk);
            chk_word(128'h2, 128'({busy, cs_n, sclk}));
        end
        test_done();
    end
endmodule // testbench

bind qsfrc_ctrl qsfrc_ctrl_chk u_chk (.sys_clk, .reset, .cfg, .start, .busy, .rd_valid,
    .word_done_irq, .frame_done_irq, .sclk, .cs_n, .dq_o);
